/* File: rtl/sdci_cfg.svh */
// Purpose: shared constants of the sdram command interface
// Assumes: 100 MHz clock on both ends
// Notes: times in ns, RP and RCD cycle counts derived from them; MRD given in cycles
`ifndef SDCI_CFG_SVH
`define SDCI_CFG_SVH
// widths of the bus
`define SDCI_BA_W 2
`define SDCI_ROW_W 12
`define SDCI_COL_W 9
`define SDCI_DQ_W 32
`define SDCI_DQM_W 4
// field positions on row_column_lines
`define SDCI_AP_BIT 10
`define SDCI_MR_BL_LSB 0
`define SDCI_MR_BT_BIT 3
`define SDCI_MR_CL_LSB 4
`define SDCI_MR_WB_BIT 9
// mode values: burst of one, sequential, latency two
`define SDCI_MR_RST 12'h020
`define SDCI_HOST_MODE 12'h020
`define SDCI_HOST_CL 4'h2
// timing
`define SDCI_CLK_NS 10
`define SDCI_T_RP_NS 20
`define SDCI_T_RCD_NS 20
`define SDCI_T_RP_CYC ((`SDCI_T_RP_NS + `SDCI_CLK_NS - 1) / `SDCI_CLK_NS)
`define SDCI_T_RCD_CYC ((`SDCI_T_RCD_NS + `SDCI_CLK_NS - 1) / `SDCI_CLK_NS)
`define SDCI_T_MRD_CYC 2
`endif

/* File: rtl/sdci_pkg.sv */
// Purpose: types of the sdram command interface
// Assumes: command code is {select, row, column, write} strobes
// Notes: a high select bit is an inhibit whatever the rest
package sdci_pkg;
    typedef enum logic [3:0] {
        SDCI_LMR = 4'h0, SDCI_REF = 4'h1, SDCI_PRE = 4'h2, SDCI_ACT = 4'h3,
        SDCI_WR = 4'h4, SDCI_RD = 4'h5, SDCI_BST = 4'h6, SDCI_NOP = 4'h7
    } sdci_cmd_t;
    typedef enum logic [4:0] {
        SDCI_PWR_RUN = 5'h01, SDCI_PWR_PDN_PRE = 5'h02, SDCI_PWR_PDN_ACT = 5'h04,
        SDCI_PWR_SELF = 5'h08, SDCI_PWR_SUSP = 5'h10
    } sdci_pwr_t;
    typedef enum logic [7:0] {
        SDCI_H_INIT = 8'h01, SDCI_H_MRS = 8'h02, SDCI_H_IDLE = 8'h04, SDCI_H_ACT = 8'h08,
        SDCI_H_RW = 8'h10, SDCI_H_RD = 8'h20, SDCI_H_WAIT = 8'h40, SDCI_H_PDN = 8'h80
    } sdci_hst_t;
endpackage

/* File: rtl/sdci_if.sv */
// Purpose: pins between memory controller and sdram device
// Assumes: each end drives data_lines with an active low enable
// Notes: an undriven byte reads as zero
`timescale 1ns/1ps
`include "sdci_cfg.svh"
interface sdci_if;
    logic cke;
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [`SDCI_BA_W-1:0] bank_select_bits;
    logic [`SDCI_ROW_W-1:0] row_column_lines;
    logic [`SDCI_DQM_W-1:0] dqm;
    logic [`SDCI_DQ_W-1:0] host_dq_o;
    logic host_dq_oe_b;
    logic [`SDCI_DQ_W-1:0] dev_dq_o;
    logic [`SDCI_DQM_W-1:0] dev_dq_oe_b;
    logic [`SDCI_DQ_W-1:0] data_lines;
    // resolve the shared data wire byte by byte
    always_comb
    begin
        for (int k = 0; k < `SDCI_DQM_W; k++)
        begin
            if (!dev_dq_oe_b[k])
                data_lines[8*k +: 8] = dev_dq_o[8*k +: 8];
            else if (!host_dq_oe_b)
                data_lines[8*k +: 8] = host_dq_o[8*k +: 8];
            else
                data_lines[8*k +: 8] = 8'h00;
        end
    end
    modport host (output cke, cs_b, ras_b, cas_b, we_b, bank_select_bits,
        row_column_lines, dqm, host_dq_o, host_dq_oe_b, input data_lines);
    modport dev (input cke, cs_b, ras_b, cas_b, we_b, bank_select_bits,
        row_column_lines, dqm, data_lines, output dev_dq_o, dev_dq_oe_b);
endinterface

/* File: rtl/sdci_dev.sv */
// Purpose: sdram device end, four banks of rows, columns, 32-bit words
// Assumes: controller keeps activation and timing order
// Notes: storage width STORE_AW shrinks the array for simulation
// Operation
// - inputs taken only on rising clock edge
// - four banks, 4096 rows, 512 columns, 32 bits
// - controller activates row before read or write
// - activate takes bank bits and row lines
// - read/write address is burst start column
// - burst 1,2,4,8, full page, terminate command
// - columns generated internally in programmed order
// - auto precharge starts when burst completes
// - new column accepted on every clock
// - banks precharge while others keep working
// - enabled edge advances counter and output registers
// - clock gate high acts, low ignores clock
// - gate low picks power-down, self refresh, suspend
// - clock gate sensed until low-power exit
// - receivers off in power-down and self refresh
// - controller may tie clock gate high
// - select high masks all commands
// - command from strobes plus select, one cycle
// - byte mask blocks writes, floats reads two-clock
// - precharge flag: auto precharge or all banks
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "sdci_cfg.svh"
module sdci_dev #(
    parameter int STORE_AW = `SDCI_BA_W + `SDCI_ROW_W + `SDCI_COL_W
) (
    sdci_if.dev sd,
    input wire logic clk,
    input wire logic rst_b,
    output sdci_pkg::sdci_pwr_t pwr_mode,
    output logic [3:0] bank_open
);
    localparam int NB = 1 << `SDCI_BA_W;
    localparam int CW = `SDCI_COL_W;
    localparam int RW = `SDCI_ROW_W;
    localparam int FW = `SDCI_BA_W + RW + CW;

    if (STORE_AW < 1 || STORE_AW > FW)
    begin : g_chk
        $error("STORE_AW out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // burst mask from mode, single write when write burst bit set
    function automatic logic [CW-1:0] bl_mask(input logic [RW-1:0] m, input logic wr);
        logic [CW-1:0] r;
        r = '0;
        case (m[`SDCI_MR_BL_LSB +: 3])
            3'h1: r = 9'h001;
            3'h2: r = 9'h003;
            3'h3: r = 9'h007;
            3'h7: r = 9'h1ff;
            default: r = '0;
        endcase
        if (wr && m[`SDCI_MR_WB_BIT])
            r = '0;
        return r;
    endfunction

    // column of step idx inside a burst from start st
    function automatic logic [CW-1:0] col_at(input logic [CW-1:0] st,
        input logic [CW-1:0] idx, input logic [CW-1:0] msk, input logic il);
        logic [CW-1:0] lo;
        lo = il ? ((st ^ idx) & msk) : CW'((st + idx) & msk);
        return (st & ~msk) | lo;
    endfunction

    // flat storage index of bank, row, column
    function automatic logic [STORE_AW-1:0] m_idx(input logic [1:0] b,
        input logic [RW-1:0] r, input logic [CW-1:0] c);
        logic [FW-1:0] f;
        f = {b, r, c};
        return f[STORE_AW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    sdci_pkg::sdci_pwr_t pwr_ff;
    logic [RW-1:0] mode_ff;
    logic [NB-1:0] open_ff;
    logic [RW-1:0] row_ff [NB];
    logic [3:0] pcnt_ff [NB];
    logic burst_ff, bwr_ff, bap_ff, bfull_ff;
    logic [1:0] bbank_ff;
    logic [CW-1:0] bstart_ff, bidx_ff, bmask_ff;
    logic rv0_ff, rv1_ff;
    logic [`SDCI_DQ_W-1:0] rd0_ff, rd1_ff, dq_ff;
    logic [`SDCI_DQM_W-1:0] dqm1_ff, oe_b_ff;
    logic [`SDCI_DQ_W-1:0] mem [2**STORE_AW];

    // command decode, sampled at the edge only
    wire [3:0] cmd = {sd.cs_b, sd.ras_b, sd.cas_b, sd.we_b};
    wire [1:0] ba = sd.bank_select_bits;
    wire [RW-1:0] ad = sd.row_column_lines;
    // clock gate, receivers off outside run
    wire go = (pwr_ff == sdci_pkg::SDCI_PWR_RUN) && sd.cke;
    // select is part of the command code
    wire c_act = go && (cmd == sdci_pkg::SDCI_ACT);
    wire c_rd = go && (cmd == sdci_pkg::SDCI_RD);
    wire c_wr = go && (cmd == sdci_pkg::SDCI_WR);
    wire c_pre = go && (cmd == sdci_pkg::SDCI_PRE);
    wire c_bst = go && (cmd == sdci_pkg::SDCI_BST);
    wire c_lmr = go && (cmd == sdci_pkg::SDCI_LMR);
    wire ap_flag = ad[`SDCI_AP_BIT];
    wire [CW-1:0] new_mask = bl_mask(mode_ff, c_wr);

    // access of this edge: new command or next burst step
    // new column restarts the burst
    wire acc_new = (c_rd || c_wr) && open_ff[ba];
    wire [CW-1:0] nidx = CW'(bidx_ff + 1'b1);
    wire pre_hits_burst = c_pre && (ap_flag || ba == bbank_ff);
    wire acc_cont = go && burst_ff && !acc_new && !c_bst && !pre_hits_burst;
    wire acc_v = acc_new || acc_cont;
    wire acc_wr = acc_new ? c_wr : bwr_ff;
    wire [1:0] acc_bank = acc_new ? ba : bbank_ff;
    wire [CW-1:0] acc_col = acc_new ? ad[CW-1:0]
        : col_at(bstart_ff, nidx, bmask_ff, mode_ff[`SDCI_MR_BT_BIT]);
    wire end_now = acc_new ? (new_mask == '0)
        : (acc_cont && !bfull_ff && nidx == bmask_ff);
    // self-timed precharge at burst end or when a new read or write interrupts the burst
    wire ap_now = end_now && (acc_new ? ap_flag : bap_ff);
    wire ap_intr = acc_new && burst_ff && bap_ff;
    wire [STORE_AW-1:0] a_idx = m_idx(acc_bank, row_ff[acc_bank], acc_col);
    wire [`SDCI_DQ_W-1:0] rdat = mem[a_idx];
    wire [2:0] cl = mode_ff[`SDCI_MR_CL_LSB +: 3];
    wire out_v = (cl == 3'h1) ? (acc_v && !acc_wr) : (cl == 3'h2) ? rv0_ff : rv1_ff;
    wire [`SDCI_DQ_W-1:0] out_d = (cl == 3'h1) ? rdat : (cl == 3'h2) ? rd0_ff : rd1_ff;

    // per bank precharge start
    logic [NB-1:0] pre_go;
    always_comb
    begin
        for (int b = 0; b < NB; b++)
        begin
            pre_go[b] = (c_pre && (ap_flag || ba == 2'(b)))
                || (ap_now && acc_bank == 2'(b)) || (ap_intr && bbank_ff == 2'(b));
        end
    end

    assign pwr_mode = pwr_ff;
    assign bank_open = open_ff;
    assign sd.dev_dq_o = dq_ff;
    assign sd.dev_dq_oe_b = oe_b_ff;

    ////////////////////////////////////////////////////////////////////////
    // power state
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            pwr_ff <= sdci_pkg::SDCI_PWR_RUN;
        // choose low-power state from burst state, bank state and a refresh command
        else if (pwr_ff == sdci_pkg::SDCI_PWR_RUN && !sd.cke)
            pwr_ff <= burst_ff ? sdci_pkg::SDCI_PWR_SUSP
                : (|open_ff) ? sdci_pkg::SDCI_PWR_PDN_ACT
                : (cmd == sdci_pkg::SDCI_REF) ? sdci_pkg::SDCI_PWR_SELF
                : sdci_pkg::SDCI_PWR_PDN_PRE;
        // gate watched every edge until exit
        else if (pwr_ff != sdci_pkg::SDCI_PWR_RUN && sd.cke)
            pwr_ff <= sdci_pkg::SDCI_PWR_RUN;
    end

    // banks: activation and self-timed precharge
    always_ff @(posedge clk)
    begin
        for (int b = 0; b < NB; b++)
        begin
            if (!rst_b)
            begin
                open_ff[b] <= 1'b0;
                row_ff[b] <= '0;
                pcnt_ff[b] <= 4'h0;
            end
            // each bank has its own precharge timer
            else if (pre_go[b] && open_ff[b])
            begin
                open_ff[b] <= 1'b0;
                pcnt_ff[b] <= 4'(`SDCI_T_RP_CYC);
            end
            // bank bits and row lines on activate
            else if (c_act && ba == 2'(b) && !open_ff[b] && pcnt_ff[b] == 4'h0)
            begin
                open_ff[b] <= 1'b1;
                row_ff[b] <= ad;
            end
            else if (pcnt_ff[b] != 4'h0)
                pcnt_ff[b] <= pcnt_ff[b] - 4'h1;
        end
    end

    // mode and burst counter
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mode_ff <= `SDCI_MR_RST;
            {burst_ff, bwr_ff, bap_ff, bfull_ff} <= 4'h0;
            bbank_ff <= 2'h0;
            {bstart_ff, bidx_ff, bmask_ff} <= '0;
        end
        else
        begin
            if (c_lmr && !(|open_ff))
                mode_ff <= ad;
            // enabled edge advances the burst counter
            if (acc_new)
            begin
                burst_ff <= !end_now;
                {bwr_ff, bap_ff, bbank_ff} <= {c_wr, ap_flag, ba};
                bfull_ff <= (mode_ff[`SDCI_MR_BL_LSB +: 3] == 3'h7) && new_mask == 9'h1ff;
                {bstart_ff, bidx_ff, bmask_ff} <= {ad[CW-1:0], {CW{1'b0}}, new_mask};
            end
            else if (acc_cont)
            begin
                bidx_ff <= nidx;
                burst_ff <= !end_now;
            end
            else if (go && burst_ff)
                burst_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        for (int k = 0; k < `SDCI_DQM_W; k++)
            if (acc_v && acc_wr && !sd.dqm[k])
                mem[a_idx][8*k +: 8] <= sd.data_lines[8*k +: 8];
    end

    // read latency pipe and output registers, frozen in suspend
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            {rv0_ff, rv1_ff} <= 2'h0;
            {rd0_ff, rd1_ff, dq_ff} <= '0;
            dqm1_ff <= '0;
            oe_b_ff <= '1;
        end
        // outputs clocked on enabled edges; drive enables forced off in power-down and self refresh
        else if (go)
        begin
            {rv0_ff, rd0_ff} <= {acc_v && !acc_wr, rdat};
            {rv1_ff, rd1_ff} <= {rv0_ff, rd0_ff};
            dqm1_ff <= sd.dqm;
            dq_ff <= out_d;
            for (int k = 0; k < `SDCI_DQM_W; k++)
                oe_b_ff[k] <= !(out_v && !dqm1_ff[k]);
        end
        else if (pwr_ff != sdci_pkg::SDCI_PWR_SUSP && pwr_ff != sdci_pkg::SDCI_PWR_RUN)
            oe_b_ff <= '1;
    end
endmodule

/* File: rtl/sdci_host.sv */
// Purpose: memory controller end, single-word accesses
// Assumes: device programmed for burst of one, latency two
// Notes: tracks open rows per bank, opens a row before access
`timescale 1ns/1ps
`include "sdci_cfg.svh"
module sdci_host (
    sdci_if.host sd,
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ap,
    input wire logic [1:0] req_bank,
    input wire logic [11:0] req_row,
    input wire logic [8:0] req_col,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_mask,
    input wire logic pd_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata
);
    sdci_pkg::sdci_hst_t st_ff, ret_ff;
    logic [3:0] cnt_ff, cmd_ff, dqm_ff, open_ff;
    logic [11:0] row_ff [4];
    logic [11:0] ad_ff, q_row;
    logic [1:0] ba_ff, q_bank;
    logic [8:0] q_col;
    logic [31:0] q_data, dqo_ff, rdat_ff;
    logic [3:0] q_mask;
    logic q_wr, q_ap, cke_ff, oe_b_ff, rdy_ff, rv_ff;

    // hit on the row already open in the requested bank
    wire hit = open_ff[req_bank] && row_ff[req_bank] == req_row;

    assign {sd.cs_b, sd.ras_b, sd.cas_b, sd.we_b} = cmd_ff;
    assign sd.cke = cke_ff;
    assign sd.bank_select_bits = ba_ff;
    assign sd.row_column_lines = ad_ff;
    assign sd.dqm = dqm_ff;
    assign sd.host_dq_o = dqo_ff;
    assign sd.host_dq_oe_b = oe_b_ff;
    assign req_ready = rdy_ff;
    assign rsp_valid = rv_ff;
    assign rsp_rdata = rdat_ff;

    ////////////////////////////////////////////////////////////////////////
    // controller sequence
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            st_ff <= sdci_pkg::SDCI_H_INIT;
            ret_ff <= sdci_pkg::SDCI_H_IDLE;
            {cnt_ff, dqm_ff, open_ff} <= '0;
            cmd_ff <= sdci_pkg::SDCI_NOP;
            {ad_ff, ba_ff, dqo_ff, rdat_ff} <= '0;
            {q_row, q_bank, q_col, q_data, q_mask, q_wr, q_ap} <= '0;
            for (int b = 0; b < 4; b++)
                row_ff[b] <= '0;
            {cke_ff, oe_b_ff, rdy_ff, rv_ff} <= 4'hc;
        end
        else
        begin
            cmd_ff <= sdci_pkg::SDCI_NOP;
            oe_b_ff <= 1'b1;
            rv_ff <= 1'b0;
            unique case (st_ff)
                sdci_pkg::SDCI_H_INIT:
                begin
                    cmd_ff <= sdci_pkg::SDCI_PRE;
                    ad_ff <= 12'h400;
                    cnt_ff <= 4'(`SDCI_T_RP_CYC);
                    ret_ff <= sdci_pkg::SDCI_H_MRS;
                    st_ff <= sdci_pkg::SDCI_H_WAIT;
                end
                sdci_pkg::SDCI_H_MRS:
                begin
                    cmd_ff <= sdci_pkg::SDCI_LMR;
                    {ad_ff, ba_ff} <= {`SDCI_HOST_MODE, 2'h0};
                    cnt_ff <= 4'(`SDCI_T_MRD_CYC);
                    ret_ff <= sdci_pkg::SDCI_H_IDLE;
                    st_ff <= sdci_pkg::SDCI_H_WAIT;
                end
                sdci_pkg::SDCI_H_WAIT:
                begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff <= 4'h1)
                    begin
                        st_ff <= ret_ff;
                        rdy_ff <= ret_ff == sdci_pkg::SDCI_H_IDLE;
                    end
                end
                sdci_pkg::SDCI_H_IDLE:
                begin
                    dqm_ff <= 4'h0;
                    if (req_valid && rdy_ff)
                    begin
                        rdy_ff <= 1'b0;
                        {q_row, q_bank, q_col, q_data} <= {req_row, req_bank, req_col, req_wdata};
                        {q_mask, q_wr, q_ap} <= {req_mask, req_write, req_ap};
                        // open the row first unless it is already open
                        if (hit)
                            st_ff <= sdci_pkg::SDCI_H_RW;
                        else if (open_ff[req_bank])
                        begin
                            cmd_ff <= sdci_pkg::SDCI_PRE;
                            {ba_ff, ad_ff} <= {req_bank, 12'h000};
                            open_ff[req_bank] <= 1'b0;
                            cnt_ff <= 4'(`SDCI_T_RP_CYC);
                            ret_ff <= sdci_pkg::SDCI_H_ACT;
                            st_ff <= sdci_pkg::SDCI_H_WAIT;
                        end
                        else
                            st_ff <= sdci_pkg::SDCI_H_ACT;
                    end
                    else if (pd_req)
                    begin
                        {cke_ff, rdy_ff} <= 2'h0;
                        st_ff <= sdci_pkg::SDCI_H_PDN;
                    end
                end
                sdci_pkg::SDCI_H_ACT:
                begin
                    // bank bits and row lines on activate
                    cmd_ff <= sdci_pkg::SDCI_ACT;
                    {ba_ff, ad_ff} <= {q_bank, q_row};
                    open_ff[q_bank] <= 1'b1;
                    row_ff[q_bank] <= q_row;
                    cnt_ff <= 4'(`SDCI_T_RCD_CYC);
                    ret_ff <= sdci_pkg::SDCI_H_RW;
                    st_ff <= sdci_pkg::SDCI_H_WAIT;
                end
                sdci_pkg::SDCI_H_RW:
                begin
                    // start column with strobes in one cycle
                    cmd_ff <= q_wr ? sdci_pkg::SDCI_WR : sdci_pkg::SDCI_RD;
                    ba_ff <= q_bank;
                    ad_ff <= {1'b0, q_ap, 1'b0, q_col};
                    {dqm_ff, dqo_ff, oe_b_ff} <= {q_mask, q_data, !q_wr};
                    if (q_ap)
                        open_ff[q_bank] <= 1'b0;
                    if (!q_wr)
                    begin
                        cnt_ff <= `SDCI_HOST_CL;
                        st_ff <= sdci_pkg::SDCI_H_RD;
                    end
                    else if (q_ap)
                    begin
                        cnt_ff <= 4'(`SDCI_T_RP_CYC + 1);
                        ret_ff <= sdci_pkg::SDCI_H_IDLE;
                        st_ff <= sdci_pkg::SDCI_H_WAIT;
                    end
                    else
                    begin
                        rdy_ff <= 1'b1;
                        st_ff <= sdci_pkg::SDCI_H_IDLE;
                    end
                end
                sdci_pkg::SDCI_H_RD:
                begin
                    cnt_ff <= cnt_ff - 4'h1;
                    if (cnt_ff == 4'h0)
                    begin
                        {rdat_ff, rv_ff} <= {sd.data_lines, 1'b1};
                        cnt_ff <= 4'(`SDCI_T_RP_CYC);
                        ret_ff <= sdci_pkg::SDCI_H_IDLE;
                        st_ff <= sdci_pkg::SDCI_H_WAIT;
                    end
                end
                sdci_pkg::SDCI_H_PDN:
                begin
                    if (!pd_req)
                    begin
                        {cke_ff, cnt_ff} <= {1'b1, 4'h1};
                        ret_ff <= sdci_pkg::SDCI_H_IDLE;
                        st_ff <= sdci_pkg::SDCI_H_WAIT;
                    end
                end
            endcase
        end
    end
endmodule

/* File: test/sdci_props.sv */
// Purpose: checks on the pins between host and device
// Assumes: host uses burst of one and latency two
// Notes: command code is {cs_b, ras_b, cas_b, we_b}
`timescale 1ns/1ps
`include "sdci_cfg.svh"
module sdci_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic ras_b,
    input wire logic cas_b,
    input wire logic we_b,
    input wire logic [`SDCI_ROW_W-1:0] row_column_lines,
    input wire logic [`SDCI_DQM_W-1:0] dqm,
    input wire logic host_dq_oe_b,
    input wire logic [`SDCI_DQM_W-1:0] dev_dq_oe_b
);
    // command decode
    wire logic [3:0] cmd = {cs_b, ras_b, cas_b, we_b};
    wire logic rd = cmd == 4'h5;
    wire logic wr = cmd == 4'h4;
    wire logic act = cmd == 4'h3;
    wire logic pre = cmd == 4'h2;
    logic act_seen_ff;
    // remembers that some row was opened
    always_ff @(posedge clk)
        act_seen_ff <= rst_b && (act_seen_ff || act);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_mask_float; ((~dev_dq_oe_b) & $past(dqm, 2)) == 4'h0; endproperty
    property p_data_after_rd; (dev_dq_oe_b != 4'hf) |-> $past(rd && cke, 2); endproperty
    property p_wr_drive; !host_dq_oe_b |-> wr; endproperty
    property p_no_clash; !(!host_dq_oe_b && dev_dq_oe_b != 4'hf); endproperty
    property p_act_first; (rd || wr) |-> act_seen_ff; endproperty
    property p_rcd; act |=> !(rd || wr); endproperty
    property p_pdn_quiet; (!cke && !$past(cke)) |-> dev_dq_oe_b == 4'hf; endproperty
    property p_init_pre; $rose(rst_b) |-> ##[0:4] (pre && row_column_lines[10]); endproperty
    a_mask_float: assert property (p_mask_float) else $error("masked byte driven");
    a_data_after_rd: assert property (p_data_after_rd) else $error("data without read");
    a_wr_drive: assert property (p_wr_drive) else $error("host drives off write");
    a_no_clash: assert property (p_no_clash) else $error("both ends drive");
    a_act_first: assert property (p_act_first) else $error("access before open");
    a_rcd: assert property (p_rcd) else $error("access right after open");
    a_pdn_quiet: assert property (p_pdn_quiet) else $error("data in power-down");
    a_init_pre: assert property (p_init_pre) else $error("no precharge all");
    c_read: cover property (rd);
    c_mask_wr: cover property (wr && dqm != 4'h0);
    c_pdn: cover property ($fell(cke));
endmodule

/* File: test/tb_top.sv */
// Purpose: runs host and device against each other
// Assumes: storage shrunk to ten index bits
// Notes: a second device is driven by hand for refusals
`timescale 1ns/1ps
`include "sdci_cfg.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_ap = 1'b0, pd_req = 1'b0;
    logic [1:0] req_bank = 2'h0;
    logic [11:0] req_row = 12'h000;
    logic [8:0] req_col = 9'h000;
    logic [31:0] req_wdata = 32'h00000000, rsp_rdata;
    logic [3:0] req_mask = 4'h0, bank_open, bank_open2;
    logic req_ready, rsp_valid;
    sdci_pkg::sdci_pwr_t pwr_mode, pwr_mode2;
    int err_count = 0, n_compared = 0, n;
    sdci_if sd();
    sdci_if sd2();
    sdci_host sdci_host_inst (.sd(sd), .clk(clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_write(req_write), .req_ap(req_ap), .req_bank(req_bank), .req_row(req_row),
        .req_col(req_col), .req_wdata(req_wdata), .req_mask(req_mask), .pd_req(pd_req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    sdci_dev #(.STORE_AW(10)) sdci_dev_inst (.sd(sd), .clk(clk), .rst_b(rst_b),
        .pwr_mode(pwr_mode), .bank_open(bank_open));
    sdci_dev #(.STORE_AW(10)) sdci_dev_inst_b (.sd(sd2), .clk(clk), .rst_b(rst_b),
        .pwr_mode(pwr_mode2), .bank_open(bank_open2));
    sdci_props sdci_props_inst (.clk(clk), .rst_b(rst_b), .cke(sd.cke), .cs_b(sd.cs_b),
        .ras_b(sd.ras_b), .cas_b(sd.cas_b), .we_b(sd.we_b),
        .row_column_lines(sd.row_column_lines), .dqm(sd.dqm),
        .host_dq_oe_b(sd.host_dq_oe_b), .dev_dq_oe_b(sd.dev_dq_oe_b));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // a limit that ran out ends the run
    task automatic bail();
        if (n >= 80)
        begin
            err_count++;
            tally_and_finish();
        end
    endtask
    // one user request, held until taken; reads wait for the answer
    task automatic access(input logic w, ap, input logic [1:0] b, input logic [11:0] r,
        input logic [8:0] c, input logic [31:0] d, input logic [3:0] m);
        req_valid <= 1'b1;
        req_write <= w;
        req_ap <= ap;
        req_bank <= b;
        req_row <= r;
        req_col <= c;
        req_wdata <= d;
        req_mask <= m;
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        req_valid <= 1'b0;
        bail();
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 80)
        begin
            @(posedge clk);
            n++;
        end
        bail();
        @(posedge clk);
    endtask
    // one command to the hand-driven device, then idle
    task automatic dcmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        {sd2.cs_b, sd2.ras_b, sd2.cas_b, sd2.we_b} <= c;
        sd2.bank_select_bits <= b;
        sd2.row_column_lines <= a;
        @(posedge clk);
        {sd2.cs_b, sd2.ras_b, sd2.cas_b, sd2.we_b} <= 4'h7;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {sd2.cke, sd2.cs_b, sd2.ras_b, sd2.cas_b, sd2.we_b, sd2.host_dq_oe_b} = 6'h3f;
        sd2.bank_select_bits = 2'h0;
        sd2.row_column_lines = 12'h000;
        sd2.dqm = 4'h0;
        sd2.host_dq_o = 32'h00000000;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        access(1'b1, 1'b0, 2'h1, 12'h005, 9'h003, 32'h11223344, 4'h0);
        access(1'b0, 1'b0, 2'h1, 12'h005, 9'h003, 32'h0, 4'h0);
        chk("read word", 32'h11223344, rsp_rdata);
        access(1'b1, 1'b0, 2'h1, 12'h005, 9'h003, 32'haabbccdd, 4'h2);
        access(1'b0, 1'b0, 2'h1, 12'h005, 9'h003, 32'h0, 4'h0);
        chk("masked write", 32'haabb33dd, rsp_rdata);
        access(1'b0, 1'b0, 2'h1, 12'h005, 9'h003, 32'h0, 4'h1);
        chk("masked read", 32'haabb3300, rsp_rdata);
        $display("test mask done");
        access(1'b1, 1'b0, 2'h2, 12'h009, 9'h007, 32'h0badf00d, 4'h0);
        // the activate reaches the device two edges after the write is taken
        repeat (2) @(posedge clk);
        chk("banks open", 32'h6, bank_open);
        access(1'b0, 1'b1, 2'h2, 12'h009, 9'h007, 32'h0, 4'h0);
        chk("second bank", 32'h0badf00d, rsp_rdata);
        repeat (4) @(posedge clk);
        chk("auto precharge", 32'h2, bank_open);
        $display("test banks done");
        pd_req <= 1'b1;
        repeat (6) @(posedge clk);
        chk("power-down", 32'(sdci_pkg::SDCI_PWR_PDN_ACT), pwr_mode);
        pd_req <= 1'b0;
        repeat (4) @(posedge clk);
        chk("wake", 32'(sdci_pkg::SDCI_PWR_RUN), pwr_mode);
        access(1'b0, 1'b0, 2'h1, 12'h005, 9'h003, 32'h0, 4'h0);
        chk("after wake", 32'haabb33dd, rsp_rdata);
        $display("test power done");
        dcmd(4'hb, 2'h2, 12'h001);
        chk("inhibited open", 32'h0, bank_open2);
        dcmd(4'h3, 2'h2, 12'h001);
        chk("open bank", 32'h4, bank_open2);
        dcmd(4'h2, 2'h0, 12'h400);
        chk("precharge all", 32'h0, bank_open2);
        dcmd(4'h5, 2'h2, 12'h000);
        chk("closed read", 32'hf, sd2.dev_dq_oe_b);
        // burst of four, latency two: data still driven four edges after the read
        dcmd(4'h0, 2'h0, 12'h022);
        dcmd(4'h3, 2'h0, 12'h001);
        dcmd(4'h5, 2'h0, 12'h000);
        repeat (2) @(posedge clk);
        chk("burst of four", 32'h0, sd2.dev_dq_oe_b);
        $display("test refusals done");
        tally_and_finish();
    end
endmodule
